// file: dv/iowef_asserts.sv
// Port checker for the I/O watchdog and event flag block.
// Assumes it is bound onto iowef_top; shadows four of the written registers.
`timescale 1ns/10ps
module iowef_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [63:0] reg_wdata,
  input wire logic [63:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [23:0] io_out_norm,
  input wire logic [23:0] io_oe_norm,
  input wire logic [23:0] io_out,
  input wire logic [23:0] io_oe,
  input wire logic shared_interrupt_out,
  input wire logic timeout_active
);
  logic [31:0] len_reg;
  logic [23:0] en_reg;
  logic [63:0] sel_reg;
  logic [23:0] oe_reg;
  logic [23:0] msk;
  // Shadow copies, so forced levels can be judged at the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      len_reg <= '0;
      en_reg <= '0;
      sel_reg <= '0;
      oe_reg <= '0;
    end else if (reg_wr) begin
      case (reg_sel)
        iowef_pkg::REG_WD_LEN: len_reg <= reg_wdata[31:0];
        iowef_pkg::REG_EVT_EN: en_reg <= reg_wdata[23:0];
        iowef_pkg::REG_OUT_SEL: sel_reg <= reg_wdata;
        iowef_pkg::REG_OE_LVL: oe_reg <= reg_wdata[23:0];
        default: ;
      endcase
    end
  end
  // Lines under watchdog control
  assign msk = sel_reg[55:32];

  ////////////////////////////////////////////////////////////
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read got no answer");
  property p_rv_cause; reg_rvalid |-> $past(reg_rd); endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
  property p_off; len_reg == '0 |=> !timeout_active; endproperty
  a_off: assert property (p_off) else $error("timeout with zero length");
  property p_stat; reg_rd && reg_sel == iowef_pkg::REG_WATCHDOG_CONFIG |=> reg_rdata[7] == $past(timeout_active); endproperty
  a_stat: assert property (p_stat) else $error("status bit wrong");
  property p_flag_int; $rose(timeout_active) && en_reg[iowef_pkg::FLG_WDT] |-> shared_interrupt_out; endproperty
  a_flag_int: assert property (p_flag_int) else $error("timeout flag not seen");
  property p_frc_out; timeout_active && $past(timeout_active) |-> ((io_out ^ sel_reg[23:0]) & msk) == '0; endproperty
  a_frc_out: assert property (p_frc_out) else $error("output not forced");
  property p_frc_oe; timeout_active && $past(timeout_active) |-> ((io_oe ^ oe_reg) & msk) == '0; endproperty
  a_frc_oe: assert property (p_frc_oe) else $error("enable not forced");
  property p_norm;
    !timeout_active && !$past(timeout_active) && !$past(rst) |-> io_out == $past(io_out_norm) && io_oe == $past(io_oe_norm);
  endproperty
  a_norm: assert property (p_norm) else $error("normal levels disturbed");
  c_timeout: cover property ($rose(timeout_active));
  c_flag_read: cover property (reg_rvalid && reg_rdata[11]);
  c_int_drop: cover property ($fell(shared_interrupt_out));
endmodule

bind iowef_top iowef_asserts u_chk (.clk(clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .io_out_norm(io_out_norm), .io_oe_norm(io_oe_norm), .io_out(io_out), .io_oe(io_oe),
  .shared_interrupt_out(shared_interrupt_out), .timeout_active(timeout_active));

// file: dv/iowef_far_model.sv
// Far-side model: chip selects, frame start and one input line.
// Assumes the bench picks a source by kind and runs it with go.
`timescale 1ns/10ps
module iowef_far_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] kind,
  output logic pdi_csn_pin,
  output logic ctl_csn_pin,
  output logic sof_pulse,
  output logic [23:0] io_in_pin
);
  logic [2:0] ph_reg = 3'h0;
  // Beat phase; one retrigger per eight cycles keeps spacing fixed
  always @(posedge clk) begin
    ph_reg <= #1 go ? ph_reg + 3'h1 : 3'h0;
  end
  // Selects idle high, so no stray rising edge outside a burst
  assign pdi_csn_pin = !(go && kind == 3'd0 && ph_reg[2]);
  assign ctl_csn_pin = !(go && kind == 3'd1 && ph_reg[2]);
  assign sof_pulse = go && kind == 3'd2 && ph_reg == 3'h7;
  assign io_in_pin = {23'h0, go && kind >= 3'd3 && ph_reg[2]};
endmodule

// file: dv/tb.sv
// Testbench for the I/O watchdog and event flag block.
// Assumes the far model drives pins; the bench drives registers.
`timescale 1ns/10ps
module tb;
  logic clk, rst, wr_s, rd_s, rv, sof, pcs, ccs, int_o, act, go, seen;
  logic [7:0] sel;
  logic [63:0] wd, rdat, got;
  logic [23:0] ev, in_p, out_n, oe_n, io_o, io_e;
  logic [2:0] kind;
  int err_count, total_checks;

  iowef_top u_dut (.clk(clk), .rst(rst), .reg_sel(sel), .reg_wr(wr_s), .reg_rd(rd_s), .reg_wdata(wd),
    .reg_rdata(rdat), .reg_rvalid(rv), .event_in(ev), .sof_pulse(sof), .pdi_csn_pin(pcs),
    .ctl_csn_pin(ccs), .io_in_pin(in_p), .io_out_norm(out_n), .io_oe_norm(oe_n), .io_out(io_o),
    .io_oe(io_e), .shared_interrupt_out(int_o), .timeout_active(act));
  iowef_far_model u_far (.clk(clk), .go(go), .kind(kind), .pdi_csn_pin(pcs), .ctl_csn_pin(ccs),
    .sof_pulse(sof), .io_in_pin(in_p));

  ////////////////////////////////////////////////////////////
  // Shared steps; every step starts 1 ns after a rising edge
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] s, input logic [63:0] d);
    sel = s;
    wd = d;
    wr_s = 1'b1;
    cyc(1);
    wr_s = 1'b0;
    // Idle edge, so a following write never re-raises the strobe at once
    cyc(1);
  endtask
  // Missing answer turns the data unknown, so it cannot match
  task automatic rdc(input logic [7:0] s, input logic [63:0] e);
    sel = s;
    rd_s = 1'b1;
    cyc(1);
    rd_s = 1'b0;
    // Answer stands for the one cycle after the strobe edge
    got = (rv === 1'b1) ? rdat : 'x;
    chk(got, e);
    cyc(1);
  endtask
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n) begin
      cyc(1);
      if (act === 1'b1) seen = 1'b1;
    end
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdc(iowef_pkg::REG_EVT_FLAG, 64'h0);
    rdc(iowef_pkg::REG_PEAK, 64'h0);
    rdc(iowef_pkg::REG_WD_LEN, 64'h0);
    rdc(8'h00, 64'h0);
    $display("t_regs done");
  endtask
  task automatic t_flags;
    wr(iowef_pkg::REG_EVT_EN, 64'h801);
    ev = 24'hffffff;
    cyc(1);
    ev = 24'h0;
    chk(64'(int_o), 64'h1);
    rdc(iowef_pkg::REG_EVT_FLAG, 64'h8ff7ff);
    chk(64'(int_o), 64'h0);
    rdc(iowef_pkg::REG_EVT_FLAG, 64'h0);
    ev = 24'h000200;
    cyc(1);
    ev = 24'h0;
    rdc(iowef_pkg::REG_EVT_FLAG, 64'h600);
    $display("t_flags done");
  endtask
  task automatic t_timeout;
    wr(iowef_pkg::REG_WATCHDOG_CONFIG, 64'h08);
    wr(iowef_pkg::REG_OUT_SEL, {8'h0, 24'hff00ff, 8'h0, 24'ha5a5a5});
    wr(iowef_pkg::REG_OE_LVL, 64'h00ffff);
    wr(iowef_pkg::REG_WD_LEN, 64'h8);
    watch(4);
    chk(64'(seen), 64'h0);
    watch(8);
    chk(64'(act), 64'h1);
    cyc(2);
    chk(64'(io_o), 64'(out_n & 24'h00ff00 | 24'ha5a5a5 & 24'hff00ff));
    chk(64'(io_e), 64'(oe_n & 24'h00ff00 | 24'h00ffff & 24'hff00ff));
    rdc(iowef_pkg::REG_WATCHDOG_CONFIG, 64'h88);
    rdc(iowef_pkg::REG_EVT_FLAG, 64'h800);
    rdc(iowef_pkg::REG_PEAK, 64'h8);
    kind = 3'd2;
    go = 1'b1;
    cyc(10);
    go = 1'b0;
    chk(64'(act), 64'h0);
    wr(iowef_pkg::REG_WD_LEN, 64'h0);
    rdc(iowef_pkg::REG_PEAK, 64'h0);
    $display("t_timeout done");
  endtask
  task automatic t_persist;
    wr(iowef_pkg::REG_WATCHDOG_CONFIG, 64'h09);
    wr(iowef_pkg::REG_WD_LEN, 64'h6);
    watch(12);
    chk(64'(seen), 64'h1);
    kind = 3'd2;
    go = 1'b1;
    cyc(18);
    chk(64'(act), 64'h1);
    wr(iowef_pkg::REG_WD_LEN, 64'd20);
    cyc(2);
    chk(64'(act), 64'h0);
    watch(40);
    chk(64'(seen), 64'h0);
    go = 1'b0;
    watch(30);
    chk(64'(seen), 64'h1);
    wr(iowef_pkg::REG_WD_LEN, 64'h0);
    $display("t_persist done");
  endtask
  // Each source in turn, enabled, then the selects and frame unenabled
  task automatic t_retrig;
    logic [7:0] cfg [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h00};
    wr(iowef_pkg::REG_IN_SEL, {8'h0, 24'h1, 8'h0, 24'h1});
    for (int k = 0; k < 8; k++) begin
      kind = 3'(k % 5);
      wr(iowef_pkg::REG_WATCHDOG_CONFIG, (k < 5) ? 64'(cfg[k]) : 64'h0);
      wr(iowef_pkg::REG_WD_LEN, 64'd20);
      go = 1'b1;
      watch(48);
      go = 1'b0;
      chk(64'(seen), (k < 5) ? 64'h0 : 64'h1);
      wr(iowef_pkg::REG_WD_LEN, 64'h0);
      cyc(2);
    end
    $display("t_retrig done");
  endtask

  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Watchdog, far beyond the roughly 620 cycles the tests take
  initial begin
    #(50 * 4000);
    err_count++;
    close_out();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    sel = 8'h00;
    wd = 64'h0;
    ev = 24'h0;
    go = 1'b0;
    kind = 3'd0;
    out_n = 24'h3c3c3c;
    oe_n = 24'h0f0f0f;
    err_count = 0;
    total_checks = 0;
    cyc(3);
    rst = 1'b0;
    t_regs();
    t_flags();
    t_timeout();
    t_persist();
    t_retrig();
    close_out();
  end
endmodule

// file: src/iowef_pkg.sv
// Constants for the I/O watchdog and event flag block.
// Assumes a single 20 MHz core clock with synchronous reset.
package iowef_pkg;

  //////////////////////////////////////////////////////////////////////
  // Clock rates and the fractional step of the timeout counter
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CNT_HZ = 25_000_000;
  localparam int unsigned RATE_SHIFT = 2;
  // Counter ticks per 2**RATE_SHIFT core cycles (5 per 4)
  localparam int unsigned RATE_NUM = CNT_HZ / (CLK_HZ >> RATE_SHIFT);

  //////////////////////////////////////////////////////////////////////
  // Register indices on the register port
  localparam logic [7:0] REG_EVT_EN = 8'h33;
  localparam logic [7:0] REG_EVT_FLAG = 8'h34;
  localparam logic [7:0] REG_WD_LEN = 8'h35;
  localparam logic [7:0] REG_WATCHDOG_CONFIG = 8'h36;
  localparam logic [7:0] REG_OUT_SEL = 8'h37;
  localparam logic [7:0] REG_OE_LVL = 8'h38;
  localparam logic [7:0] REG_IN_SEL = 8'h39;
  localparam logic [7:0] REG_PEAK = 8'h3a;

  //////////////////////////////////////////////////////////////////////
  // Widths and field positions
  localparam int unsigned NLINE = 24;
  localparam int unsigned NFLAG = 24;
  localparam int unsigned POL_LSB = 0;
  localparam int unsigned SEL_LSB = 32;
  localparam int unsigned FLG_I2C_RX = 8;
  localparam int unsigned FLG_I2C_TX = 9;
  localparam int unsigned FLG_I2C_ANY = 10;
  localparam int unsigned FLG_WDT = 11;
  localparam logic [23:0] FLAG_RSV_MASK = 24'h700000;
  localparam logic [23:0] FLAG_OWN_MASK = 24'h000c00;
  localparam int unsigned CFG_PERSIST = 0;
  localparam int unsigned CFG_PDI_CSN = 1;
  localparam int unsigned CFG_CTL_CSN = 2;
  localparam int unsigned CFG_SOF = 3;
  localparam int unsigned CFG_IN_EDGE = 4;
  localparam int unsigned CFG_ACTIVE = 7;
  localparam logic [7:0] CFG_WR_MASK = 8'h1f;

  //////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] LEN_RST = 32'h0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [63:0] SEL_RST = 64'h0;
  localparam logic [31:0] OE_RST = 32'h0;
  localparam logic [23:0] FLAG_RST = 24'h0;

  // Watchdog states
  typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_FORCED} iowef_wd_e;

endpackage

// file: src/iowef_rate.sv
// Fractional step source: how many 25 MHz ticks fall in each clk.
// Assumes the package ratio of counter rate to core rate.
`timescale 1ns/10ps
module iowef_rate (
  input wire logic clk,
  input wire logic rst,
  output logic [1:0] step
);

  localparam int unsigned SH = iowef_pkg::RATE_SHIFT;
  localparam logic [3:0] NUM = 4'(iowef_pkg::RATE_NUM);

  logic [SH-1:0] acc_reg;
  logic [3:0] sum;

  // Carry out of the accumulator gives the extra tick
  assign sum = {{(4-SH){1'b0}}, acc_reg} + NUM;
  assign step = sum[SH+1:SH];

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= sum[SH-1:0];
    end
  end

endmodule

// file: src/iowef_sync.sv
// Two-stage synchroniser for pin-level inputs.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/10ps
module iowef_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] sync
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second one
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      sync <= '0;
    end else begin
      meta_reg <= pin;
      sync <= meta_reg;
    end
  end

endmodule

// file: src/iowef_top.sv
// Watchdog with forced outputs and the event flag capture register.
// Assumes a one-cycle register port from the SPI front ends, event
// pulses from logic on clk, and chip selects and I/O pins from outside.
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////
// Contract
// R01: Separate read-only flag per event source
// R02: Reading flags returns them, then clears
// R03: Flag 10 is either I2C event
// R04: Nonzero length counts 25 MHz cycles
// R05: Zero length keeps watchdog off
// R06: Non-persistent timeout ends on next retrigger
// R07: Persistent timeout ends only on length write
// R08: Config bits 1,2 enable chip-select retrigger
// R09: Config bit 3 enables frame-start retrigger
// R10: Config bit 4 picks pattern edge
// R11: Config bit 7 shows active timeout
// R12: Masked outputs forced to polarity level
// R13: Forced lines take programmed output enable
// R14: Masked inputs must match polarity bits
// R15: Read-only peak of timeout counter
// R16: Length write clears peak counter
// R17: Enabled flags ORed onto interrupt pin
// R18: Counter steps, restarts, times out at length
// R19: Timeout flag set when timeout begins
module iowef_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [63:0] reg_wdata,
  output logic [63:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [23:0] event_in,
  input wire logic sof_pulse,
  input wire logic pdi_csn_pin,
  input wire logic ctl_csn_pin,
  input wire logic [23:0] io_in_pin,
  input wire logic [23:0] io_out_norm,
  input wire logic [23:0] io_oe_norm,
  output logic [23:0] io_out,
  output logic [23:0] io_oe,
  output logic shared_interrupt_out,
  output logic timeout_active
);

  //////////////////////////////////////////////////////////////////////
  // Declarations

  logic [23:0] event_enable_reg;
  logic [23:0] event_flag_reg;
  logic [23:0] event_flag_next;
  logic [23:0] flag_set;
  logic [31:0] timeout_length_reg;
  logic [7:0] watchdog_config_reg;
  logic [63:0] out_sel_reg;
  logic [31:0] oe_lvl_reg;
  logic [63:0] in_sel_reg;
  logic [31:0] peak_counter_reg;
  logic [31:0] count_reg;
  logic [32:0] count_sum;
  iowef_pkg::iowef_wd_e wd_state_reg;
  iowef_pkg::iowef_wd_e wd_state_next;

  logic wr_evt_en;
  logic wr_len;
  logic wr_cfg;
  logic wr_out_sel;
  logic wr_oe_lvl;
  logic wr_in_sel;
  logic rd_flag;

  logic [1:0] step;
  logic pdi_csn_s;
  logic ctl_csn_s;
  logic [23:0] io_in_s;
  logic pdi_csn_prev_reg;
  logic ctl_csn_prev_reg;
  logic pat_prev_reg;
  logic pat_now;
  logic pat_edge;
  logic retrig;
  logic wd_on;
  logic timeout_start;

  //////////////////////////////////////////////////////////////////////
  // Synchronisers and the counter rate

  // Chip selects come straight from pins
  iowef_sync #(
    .W(2)
  ) u_csn_sync (
    .clk(clk),
    .rst(rst),
    .pin({pdi_csn_pin, ctl_csn_pin}),
    .sync({pdi_csn_s, ctl_csn_s})
  );

  // Pattern inputs, also from pins
  iowef_sync #(
    .W(24)
  ) u_io_sync (
    .clk(clk),
    .rst(rst),
    .pin(io_in_pin),
    .sync(io_in_s)
  );

  // Counter ticks at 25 MHz, made from 20 MHz
  iowef_rate u_rate (
    .clk(clk),
    .rst(rst),
    .step(step)
  );

  //////////////////////////////////////////////////////////////////////
  // Register port decode

  // Strobes per register index
  always_comb begin
    wr_evt_en = 1'b0;
    wr_len = 1'b0;
    wr_cfg = 1'b0;
    wr_out_sel = 1'b0;
    wr_oe_lvl = 1'b0;
    wr_in_sel = 1'b0;
    if (reg_sel == iowef_pkg::REG_EVT_EN) begin
      wr_evt_en = reg_wr;
    end else if (reg_sel == iowef_pkg::REG_WD_LEN) begin
      wr_len = reg_wr;
    end else if (reg_sel == iowef_pkg::REG_WATCHDOG_CONFIG) begin
      wr_cfg = reg_wr;
    end else if (reg_sel == iowef_pkg::REG_OUT_SEL) begin
      wr_out_sel = reg_wr;
    end else if (reg_sel == iowef_pkg::REG_OE_LVL) begin
      wr_oe_lvl = reg_wr;
    end else if (reg_sel == iowef_pkg::REG_IN_SEL) begin
      wr_in_sel = reg_wr;
    end
  end

  // Write with the read taking priority is not needed: distinct strobes
  assign rd_flag = reg_rd && (reg_sel == iowef_pkg::REG_EVT_FLAG);

  // Writable control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      event_enable_reg <= iowef_pkg::FLAG_RST;
      timeout_length_reg <= iowef_pkg::LEN_RST;
      watchdog_config_reg <= iowef_pkg::CFG_RST;
      out_sel_reg <= iowef_pkg::SEL_RST;
      oe_lvl_reg <= iowef_pkg::OE_RST;
      in_sel_reg <= iowef_pkg::SEL_RST;
    end else begin
      if (wr_evt_en) begin
        event_enable_reg <= reg_wdata[23:0] & ~iowef_pkg::FLAG_RSV_MASK;
      end
      // R04: unsigned 32-bit length
      if (wr_len) begin
        timeout_length_reg <= reg_wdata[31:0];
      end
      // Active bit is status, never stored
      if (wr_cfg) begin
        watchdog_config_reg <= reg_wdata[7:0] & iowef_pkg::CFG_WR_MASK;
      end
      if (wr_out_sel) begin
        out_sel_reg <= reg_wdata;
      end
      if (wr_oe_lvl) begin
        oe_lvl_reg <= reg_wdata[31:0];
      end
      if (wr_in_sel) begin
        in_sel_reg <= reg_wdata;
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (reg_sel == iowef_pkg::REG_EVT_FLAG) begin
          // R02: old flags returned
          reg_rdata <= {40'h0, event_flag_reg};
        end else if (reg_sel == iowef_pkg::REG_WATCHDOG_CONFIG) begin
          // R11: live timeout status
          reg_rdata <= {56'h0, timeout_active, 2'h0, watchdog_config_reg[4:0]};
        end else if (reg_sel == iowef_pkg::REG_PEAK) begin
          // R15: peak readout
          reg_rdata <= {32'h0, peak_counter_reg};
        end else begin
          // Write-only and unmapped read as zero
          reg_rdata <= '0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Retrigger sources

  // Edge history at idle levels after reset; the chip-select synchronisers reset low, so one false rising edge follows
  always_ff @(posedge clk) begin
    if (rst) begin
      pdi_csn_prev_reg <= 1'b1;
      ctl_csn_prev_reg <= 1'b1;
      pat_prev_reg <= 1'b1;
    end else begin
      pdi_csn_prev_reg <= pdi_csn_s;
      ctl_csn_prev_reg <= ctl_csn_s;
      pat_prev_reg <= pat_now;
    end
  end

  // R14: selected lines must match polarity
  assign pat_now = &(~in_sel_reg[iowef_pkg::SEL_LSB +: 24]
    | ~(io_in_s ^ in_sel_reg[iowef_pkg::POL_LSB +: 24]));

  // R10: edge direction from config
  assign pat_edge = watchdog_config_reg[iowef_pkg::CFG_IN_EDGE]
    ? (pat_now && !pat_prev_reg)
    : (!pat_now && pat_prev_reg);

  // R08: rising chip selects, each enabled
  // R09: frame start when enabled
  assign retrig =
    (watchdog_config_reg[iowef_pkg::CFG_PDI_CSN] && pdi_csn_s && !pdi_csn_prev_reg)
    || (watchdog_config_reg[iowef_pkg::CFG_CTL_CSN] && ctl_csn_s && !ctl_csn_prev_reg)
    || (watchdog_config_reg[iowef_pkg::CFG_SOF] && sof_pulse)
    || pat_edge;

  //////////////////////////////////////////////////////////////////////
  // Watchdog state and counter

  // R05: zero length means off
  assign wd_on = (timeout_length_reg != 32'h0);

  // Sum is 33 bits so a huge length never wraps
  assign count_sum = {1'b0, count_reg} + {31'h0, step};

  // R18: timeout once count reaches length
  assign timeout_start = (wd_state_reg == iowef_pkg::WD_RUN) && wd_on
    && !retrig && !wr_len && (count_sum >= {1'b0, timeout_length_reg});

  // Next state
  always_comb begin
    wd_state_next = wd_state_reg;
    case (wd_state_reg)
      iowef_pkg::WD_OFF: begin
        if (wd_on) begin
          wd_state_next = iowef_pkg::WD_RUN;
        end
      end
      iowef_pkg::WD_RUN: begin
        if (!wd_on) begin
          wd_state_next = iowef_pkg::WD_OFF;
        end else if (timeout_start) begin
          wd_state_next = iowef_pkg::WD_FORCED;
        end
      end
      iowef_pkg::WD_FORCED: begin
        if (!wd_on) begin
          wd_state_next = iowef_pkg::WD_OFF;
        end else if (wr_len) begin
          // R07: rewrite of length clears
          wd_state_next = iowef_pkg::WD_RUN;
        end else if (retrig && !watchdog_config_reg[iowef_pkg::CFG_PERSIST]) begin
          // R06: retrigger ends action
          wd_state_next = iowef_pkg::WD_RUN;
        end
      end
      default: begin
        wd_state_next = iowef_pkg::WD_OFF;
      end
    endcase
  end

  // State register; a length write of zero lands in off the cycle after the length register clears
  always_ff @(posedge clk) begin
    if (rst) begin
      wd_state_reg <= iowef_pkg::WD_OFF;
    end else begin
      wd_state_reg <= wd_state_next;
    end
  end

  // R18: count steps, restarts on retrigger
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 32'h0;
    end else if (!wd_on || wr_len || retrig) begin
      count_reg <= 32'h0;
    end else if (timeout_start) begin
      count_reg <= timeout_length_reg;
    end else if (wd_state_reg == iowef_pkg::WD_RUN) begin
      count_reg <= count_sum[31:0];
    end
  end

  // Peak of the counter
  always_ff @(posedge clk) begin
    if (rst) begin
      peak_counter_reg <= 32'h0;
    end else if (wr_len) begin
      // R16: length write clears peak
      peak_counter_reg <= 32'h0;
    end else if (count_reg > peak_counter_reg) begin
      // R15: track highest count
      peak_counter_reg <= count_reg;
    end
  end

  // R11: active while forced
  assign timeout_active = (wd_state_reg == iowef_pkg::WD_FORCED);

  //////////////////////////////////////////////////////////////////////
  // Forced outputs

  // Registered so pins never glitch during the switch
  genvar gi;
  generate
    for (gi = 0; gi < iowef_pkg::NLINE; gi = gi + 1) begin : g_line
      always_ff @(posedge clk) begin
        if (rst) begin
          io_out[gi] <= 1'b0;
          io_oe[gi] <= 1'b0;
        end else if (timeout_active && out_sel_reg[iowef_pkg::SEL_LSB + gi]) begin
          // R12: forced level
          io_out[gi] <= out_sel_reg[iowef_pkg::POL_LSB + gi];
          // R13: forced direction
          io_oe[gi] <= oe_lvl_reg[gi];
        end else begin
          io_out[gi] <= io_out_norm[gi];
          io_oe[gi] <= io_oe_norm[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Event flags and interrupt

  // R01: one flag per source, reserved zero
  // R03: flag 10 from either I2C event
  // R19: timeout flag on timeout start
  always_comb begin
    flag_set = event_in & ~(iowef_pkg::FLAG_RSV_MASK | iowef_pkg::FLAG_OWN_MASK);
    flag_set[iowef_pkg::FLG_I2C_ANY] = event_in[iowef_pkg::FLG_I2C_RX]
      | event_in[iowef_pkg::FLG_I2C_TX];
    flag_set[iowef_pkg::FLG_WDT] = timeout_start;
  end

  // R02: read clears all, new set wins
  assign event_flag_next = (rd_flag ? 24'h0 : event_flag_reg) | flag_set;

  always_ff @(posedge clk) begin
    if (rst) begin
      event_flag_reg <= iowef_pkg::FLAG_RST;
    end else begin
      event_flag_reg <= event_flag_next;
    end
  end

  // R17: enabled flags ORed to pin
  always_ff @(posedge clk) begin
    if (rst) begin
      shared_interrupt_out <= 1'b0;
    end else begin
      shared_interrupt_out <= |(event_flag_next & event_enable_reg);
    end
  end

endmodule
